// ==== verilog/ebamc_pkg.sv ====
// package: constants and types for the external bus access and mode control block
package ebamc_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_BUS_IF_CTL = 8'h00;
   localparam logic [7:0] ADR_STRETCH = 8'h04;
   localparam logic [7:0] ADR_MODE = 8'h08;
   localparam logic [7:0] ADR_PORT_E = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIC_PHASE_CLOCK_STRETCH_ENABLE_BIT = 0;
   localparam int STR_CNT_LSB = 0;
   localparam int MODE_LSB = 0;
   localparam int MODE_VALID_BIT = 3;
   localparam int MODE_DBG_BIT = 4;
   localparam int PE_NMI_EN_BIT = 0;
   localparam int PE_IRQ_EN_BIT = 1;
   localparam int PE_PIN_LSB = 2;
   localparam int PE_PULL_LSB = 4;
   localparam int PE_PIPE_EN_BIT = 6;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_ERR_BIT = 1;
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic RST_PHASE_CLOCK_STRETCH_ENABLE = 1'b1;
   localparam logic [1:0] RST_STRETCH = 2'h3;
   localparam logic [1:0] RST_PULL = 2'h3;
   localparam logic [1:0] SYNC_SETTLE = 2'h3;
   localparam logic [7:0] TICK_DIV_DEF = 8'h0a;
   // ------------------------------------------------------------
   // operating modes, pin order c,b,a
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SPEC_SINGLE = 3'b000,
      MODE_EMU_NARROW = 3'b001,
      MODE_SPEC_TEST = 3'b010,
      MODE_EMU_WIDE = 3'b011,
      MODE_NORM_SINGLE = 3'b100,
      MODE_NORM_NARROW = 3'b101,
      MODE_PERIPHERAL = 3'b110,
      MODE_NORM_WIDE = 3'b111
   } ebamc_mode_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b10
   } ebamc_st_e;
endpackage

// ==== verilog/ebamc_top.sv ====
// external bus access encoding, cycle stretch and mode latch
`timescale 1ns/1ps
// Notes on behaviour
// - byte access: even gives bit0 low strobe high, odd the reverse; rw high reads
// - aligned word at even address drives strobe low and bit0 low
// - word at odd address drives strobe high, bit0 high, halves not swapped
// - strobe high with bit0 high only for internal RAM accesses
// - misaligned word: addressed byte on low half, next byte on high half
// - bus cycles stretch by 0 to 3 bus-clock periods, programmable
// - timer reference tick keeps its rate during stretch
// - cpu held in its state while a cycle is stretched
// - write data stays driven for the whole stretched period
// - read data captured at phase clock fall; partner meets setup before it
// - chip select and read/write valid through the whole stretched high phase
// - address phase is never stretched
// - three mode pins latched at reset release set the operating mode
// - mode bits readable; only restricted mode changes while running; special modes here accept any mode write
// - patterns 000 to 011: special single, emu narrow, special test, emu wide
// - patterns 100,101,111,110: normal single, narrow, wide, peripheral
// - normal modes protect controls; special modes allow wider write access
// - debug in all modes; active at reset only in special single chip
// - port e bit 1: input or maskable interrupt, inhibited at reset, pulled up
// - port e bit 0: input or nonmaskable interrupt, inhibited at reset, pulled up
// - reset sets stretch enable; pipe status pins high impedance during reset
module ebamc_top #(
   parameter logic [7:0] TICK_DIV = ebamc_pkg::TICK_DIV_DEF
) (
   input wire logic CLK_SYS_IN,
   input wire logic ARST_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic CPU_REQ_IN,
   input wire logic [15:0] CPU_ADDR_IN,
   input wire logic CPU_WE_IN,
   input wire logic CPU_WIDE_IN,
   input wire logic CPU_INT_RAM_IN,
   input wire logic [15:0] CPU_WDATA_IN,
   input wire logic [1:0] CPU_PIPE_IN,
   input wire logic DEBUG_CMD_IN,
   output logic CPU_HOLD_OUT,
   output logic CPU_DONE_OUT,
   output logic CPU_ERR_OUT,
   output logic [15:0] CPU_RDATA_OUT,
   output logic [15:0] EXT_ADDR_OUT,
   output logic ADDRESS_BIT_ZERO_OUT,
   output logic LOW_BYTE_STROBE_N_OUT,
   output logic READ_WRITE_OUT,
   output logic CHIP_SELECT_N_OUT,
   output logic BUS_PHASE_CLOCK_OUT,
   output logic [15:0] DATA_OUT,
   output logic DATA_OE_N_OUT,
   input wire logic [15:0] DATA_IN,
   input wire logic MODE_PIN_A_IN,
   input wire logic MODE_PIN_B_IN,
   input wire logic MODE_PIN_C_IN,
   input wire logic IRQ_N_IN,
   input wire logic NONMASKABLE_INTERRUPT_N_IN,
   output logic [1:0] PIPE_STATUS_OUT,
   output logic PIPE_STATUS_OE_N_OUT,
   output logic [1:0] PORT_E_PULLUP_OUT,
   output logic IRQ_REQ_OUT,
   output logic NMI_REQ_OUT,
   output logic MODE_VALID_OUT,
   output logic [2:0] MODE_OUT,
   output logic BACKGROUND_DEBUG_MODE_OUT,
   output logic TIMER_TICK_OUT
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // strobe is low for aligned words and odd bytes
   function automatic logic strobe_n_of(input logic wide, input logic a0);
      strobe_n_of = ~(wide ^ a0);
   endfunction
   // byte lanes: bits 7:0 addressed byte, 15:8 next byte; odd address puts addressed on low
   function automatic logic [15:0] lane_swap(input logic a0, input logic [15:0] v);
      lane_swap = a0 ? v : {v[7:0], v[15:8]};
   endfunction
   function automatic logic is_special(input logic [2:0] m);
      is_special = ~m[2];
   endfunction
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ebamc_pkg::ebamc_st_e st;
      logic [1:0] cnt;
      logic [1:0] lim;
      logic hold;
      logic done;
      logic err;
      logic sticky_err;
      logic [15:0] rdata;
      logic [15:0] addr;
      logic a0;
      logic low_byte_strobe_n_n;
      logic rw;
      logic cs_n;
      logic bus_phase_clock;
      logic [15:0] dout;
      logic doe_n;
      logic int_ram;
      logic phase_clock_stretch_enable;
      logic [1:0] scnt;
      logic [2:0] mode;
      logic mode_valid;
      logic mode_wr_done;
      logic ctl_wr_done;
      logic dbg_act;
      logic nmi_en;
      logic irq_en;
      logic [1:0] pull;
      logic pipe_en;
      logic [1:0] pipe;
      logic pipe_oe_n;
      logic irq_req;
      logic nmi_req;
      logic [2:0] ms1;
      logic [2:0] ms2;
      logic [2:0] ms3;
      logic [1:0] is1;
      logic [1:0] is2;
      logic [1:0] is3;
      logic [1:0] pin;
      logic [1:0] cap_cnt;
      logic ack;
      logic [31:0] wdat;
      logic [7:0] tick_cnt;
      logic tick;
   } ebamc_state_s;

   ebamc_state_s s_ff;
   ebamc_state_s nxt_s;
   logic wb_go;
   logic wb_wr;
   logic [2:0] new_mode;
   logic ctl_ok;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      nxt_s.err = 1'b0;
      nxt_s.ack = 1'b0;
      wb_go = WB_CYC_IN && WB_STB_IN && !s_ff.ack;
      wb_wr = wb_go && WB_WE_IN && WB_SEL_IN[0];
      new_mode = WB_DAT_IN[ebamc_pkg::MODE_LSB +: 3];
      // normal modes allow one write of the bus controls
      ctl_ok = is_special(s_ff.mode) || !s_ff.ctl_wr_done;
      // reference tick free-runs, untouched by the bus machine
      nxt_s.tick = 1'b0;
      if (s_ff.tick_cnt == TICK_DIV - 8'h01)
      begin
         nxt_s.tick_cnt = 8'h00;
         nxt_s.tick = 1'b1;
      end
      else
      begin
         nxt_s.tick_cnt = s_ff.tick_cnt + 8'h01;
      end
      // pin synchronisers
      nxt_s.ms1 = {MODE_PIN_C_IN, MODE_PIN_B_IN, MODE_PIN_A_IN};
      nxt_s.ms2 = s_ff.ms1;
      nxt_s.ms3 = s_ff.ms2;
      nxt_s.is1 = {IRQ_N_IN, NONMASKABLE_INTERRUPT_N_IN};
      nxt_s.is2 = s_ff.is1;
      nxt_s.is3 = s_ff.is2;
      if (s_ff.is2 == s_ff.is3)
      begin
         nxt_s.pin = s_ff.is3;
      end
      // mode latch once the synchronised pins have settled after release
      if (!s_ff.mode_valid)
      begin
         if (s_ff.cap_cnt != ebamc_pkg::SYNC_SETTLE)
         begin
            nxt_s.cap_cnt = s_ff.cap_cnt + 2'h1;
         end
         else if (s_ff.ms2 == s_ff.ms3)
         begin
            nxt_s.mode = s_ff.ms3;
            nxt_s.mode_valid = 1'b1;
            // decoding of the eight patterns lives in ebamc_mode_e
            // a debug command taken before the latch must not be lost
            nxt_s.dbg_act = s_ff.dbg_act ||
               (s_ff.ms3 == ebamc_pkg::MODE_SPEC_SINGLE);
         end
      end
      if (DEBUG_CMD_IN)
      begin
         nxt_s.dbg_act = 1'b1;
      end
      // interrupt inputs stay plain inputs until enabled
      nxt_s.irq_req = s_ff.irq_en && !s_ff.pin[1];
      nxt_s.nmi_req = s_ff.nmi_en && !s_ff.pin[0];
      // pipe status stays undriven until the mode is known
      nxt_s.pipe = CPU_PIPE_IN;
      nxt_s.pipe_oe_n = !(s_ff.mode_valid && s_ff.pipe_en);
      // register bus
      if (wb_go)
      begin
         nxt_s.ack = 1'b1;
         nxt_s.wdat = 32'h0000_0000;
         unique case (WB_ADR_IN)
            ebamc_pkg::ADR_BUS_IF_CTL:
               nxt_s.wdat[ebamc_pkg::BIC_PHASE_CLOCK_STRETCH_ENABLE_BIT] = s_ff.phase_clock_stretch_enable;
            ebamc_pkg::ADR_STRETCH:
               nxt_s.wdat[ebamc_pkg::STR_CNT_LSB +: 2] = s_ff.scnt;
            ebamc_pkg::ADR_MODE:
            begin
               nxt_s.wdat[ebamc_pkg::MODE_LSB +: 3] = s_ff.mode;
               nxt_s.wdat[ebamc_pkg::MODE_VALID_BIT] = s_ff.mode_valid;
               nxt_s.wdat[ebamc_pkg::MODE_DBG_BIT] = s_ff.dbg_act;
            end
            ebamc_pkg::ADR_PORT_E:
            begin
               nxt_s.wdat[ebamc_pkg::PE_NMI_EN_BIT] = s_ff.nmi_en;
               nxt_s.wdat[ebamc_pkg::PE_IRQ_EN_BIT] = s_ff.irq_en;
               nxt_s.wdat[ebamc_pkg::PE_PIN_LSB +: 2] = s_ff.pin;
               nxt_s.wdat[ebamc_pkg::PE_PULL_LSB +: 2] = s_ff.pull;
               nxt_s.wdat[ebamc_pkg::PE_PIPE_EN_BIT] = s_ff.pipe_en;
            end
            ebamc_pkg::ADR_STATUS:
            begin
               nxt_s.wdat[ebamc_pkg::STS_BUSY_BIT] = (s_ff.st != ebamc_pkg::ST_IDLE);
               nxt_s.wdat[ebamc_pkg::STS_ERR_BIT] = s_ff.sticky_err;
            end
            default:
               nxt_s.wdat = 32'h0000_0000;
         endcase
      end
      if (wb_wr)
      begin
         unique case (WB_ADR_IN)
            ebamc_pkg::ADR_BUS_IF_CTL:
               if (ctl_ok)
               begin
                  nxt_s.phase_clock_stretch_enable = WB_DAT_IN[ebamc_pkg::BIC_PHASE_CLOCK_STRETCH_ENABLE_BIT];
                  nxt_s.ctl_wr_done = 1'b1;
               end
            ebamc_pkg::ADR_STRETCH:
               if (ctl_ok)
               begin
                  nxt_s.scnt = WB_DAT_IN[ebamc_pkg::STR_CNT_LSB +: 2];
                  nxt_s.ctl_wr_done = 1'b1;
               end
            ebamc_pkg::ADR_MODE:
               // normal modes: one write, staying in a normal, non-peripheral mode
               if (s_ff.mode_valid && (is_special(s_ff.mode) || (!s_ff.mode_wr_done &&
                   new_mode[2] && new_mode != ebamc_pkg::MODE_PERIPHERAL)))
               begin
                  nxt_s.mode = new_mode;
                  nxt_s.mode_wr_done = 1'b1;
               end
            ebamc_pkg::ADR_PORT_E:
            begin
               nxt_s.nmi_en = WB_DAT_IN[ebamc_pkg::PE_NMI_EN_BIT];
               nxt_s.irq_en = WB_DAT_IN[ebamc_pkg::PE_IRQ_EN_BIT];
               nxt_s.pull = WB_DAT_IN[ebamc_pkg::PE_PULL_LSB +: 2];
               nxt_s.pipe_en = WB_DAT_IN[ebamc_pkg::PE_PIPE_EN_BIT];
            end
            ebamc_pkg::ADR_STATUS:
               nxt_s.sticky_err = 1'b0;
            default:
               nxt_s.sticky_err = s_ff.sticky_err;
         endcase
      end
      // external bus machine
      unique case (s_ff.st)
         ebamc_pkg::ST_IDLE:
            if (CPU_REQ_IN && s_ff.mode_valid)
            begin
               // single chip modes have no bus; misaligned words exist only for internal ram
               if (s_ff.mode == ebamc_pkg::MODE_SPEC_SINGLE ||
                   s_ff.mode == ebamc_pkg::MODE_NORM_SINGLE ||
                   (CPU_WIDE_IN && CPU_ADDR_IN[0] && !CPU_INT_RAM_IN))
               begin
                  nxt_s.done = 1'b1;
                  nxt_s.err = 1'b1;
                  nxt_s.sticky_err = 1'b1;
               end
               else
               begin
                  nxt_s.st = ebamc_pkg::ST_ADDR;
                  nxt_s.addr = CPU_ADDR_IN;
                  nxt_s.a0 = CPU_ADDR_IN[0];
                  nxt_s.low_byte_strobe_n_n = strobe_n_of(CPU_WIDE_IN,
                     CPU_ADDR_IN[0]);
                  nxt_s.rw = !CPU_WE_IN;
                  nxt_s.int_ram = CPU_INT_RAM_IN;
                  nxt_s.cs_n = 1'b0;
                  nxt_s.dout = lane_swap(CPU_ADDR_IN[0], CPU_WDATA_IN);
                  nxt_s.lim = s_ff.phase_clock_stretch_enable ? s_ff.scnt : 2'h0;
               end
            end
         ebamc_pkg::ST_ADDR:
         begin
            // address phase is always exactly one period
            nxt_s.st = ebamc_pkg::ST_DATA;
            nxt_s.bus_phase_clock = 1'b1;
            nxt_s.cnt = 2'h0;
            nxt_s.doe_n = s_ff.rw;
            nxt_s.hold = (s_ff.lim != 2'h0);
         end
         ebamc_pkg::ST_DATA:
            if (s_ff.cnt == s_ff.lim)
            begin
               // falling edge of the phase clock: capture read data and end the cycle
               nxt_s.st = ebamc_pkg::ST_IDLE;
               nxt_s.bus_phase_clock = 1'b0;
               nxt_s.cs_n = 1'b1;
               nxt_s.doe_n = 1'b1;
               nxt_s.done = 1'b1;
               if (s_ff.rw)
               begin
                  nxt_s.rdata = lane_swap(s_ff.a0, DATA_IN);
               end
            end
            else
            begin
               // stretch: phase clock stays high, cpu held until the last period
               nxt_s.cnt = s_ff.cnt + 2'h1;
               nxt_s.hold = (s_ff.cnt + 2'h1 != s_ff.lim);
            end
         default:
            nxt_s.st = ebamc_pkg::ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         s_ff <= '0;
         s_ff.st <= ebamc_pkg::ST_IDLE;
         s_ff.low_byte_strobe_n_n <= 1'b1;
         s_ff.rw <= 1'b1;
         s_ff.cs_n <= 1'b1;
         s_ff.doe_n <= 1'b1;
         s_ff.phase_clock_stretch_enable <= ebamc_pkg::RST_PHASE_CLOCK_STRETCH_ENABLE;
         s_ff.scnt <= ebamc_pkg::RST_STRETCH;
         s_ff.pull <= ebamc_pkg::RST_PULL;
         s_ff.pipe_oe_n <= 1'b1;
         s_ff.ms1 <= 3'h7;
         s_ff.ms2 <= 3'h7;
         s_ff.ms3 <= 3'h7;
         s_ff.is1 <= 2'h3;
         s_ff.is2 <= 2'h3;
         s_ff.is3 <= 2'h3;
         s_ff.pin <= 2'h3;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign WB_DAT_OUT = s_ff.wdat;
   assign WB_ACK_OUT = s_ff.ack;
   assign CPU_HOLD_OUT = s_ff.hold;
   assign CPU_DONE_OUT = s_ff.done;
   assign CPU_ERR_OUT = s_ff.err;
   assign CPU_RDATA_OUT = s_ff.rdata;
   assign EXT_ADDR_OUT = s_ff.addr;
   assign ADDRESS_BIT_ZERO_OUT = s_ff.a0;
   assign LOW_BYTE_STROBE_N_OUT = s_ff.low_byte_strobe_n_n;
   assign READ_WRITE_OUT = s_ff.rw;
   assign CHIP_SELECT_N_OUT = s_ff.cs_n;
   assign BUS_PHASE_CLOCK_OUT = s_ff.bus_phase_clock;
   assign DATA_OUT = s_ff.dout;
   assign DATA_OE_N_OUT = s_ff.doe_n;
   assign PIPE_STATUS_OUT = s_ff.pipe;
   assign PIPE_STATUS_OE_N_OUT = s_ff.pipe_oe_n;
   assign PORT_E_PULLUP_OUT = s_ff.pull;
   assign IRQ_REQ_OUT = s_ff.irq_req;
   assign NMI_REQ_OUT = s_ff.nmi_req;
   assign MODE_VALID_OUT = s_ff.mode_valid;
   assign MODE_OUT = s_ff.mode;
   assign BACKGROUND_DEBUG_MODE_OUT = s_ff.dbg_act;
   assign TIMER_TICK_OUT = s_ff.tick;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!ARST_N_IN);

   property p_strobe_code;
      (s_ff.st == ebamc_pkg::ST_IDLE && CPU_REQ_IN && nxt_s.st == ebamc_pkg::ST_ADDR) |=>
         LOW_BYTE_STROBE_N_OUT == ~($past(CPU_WIDE_IN) ^ $past(CPU_ADDR_IN[0])) &&
         READ_WRITE_OUT == !$past(CPU_WE_IN);
   endproperty
   a_strobe_code: assert property (p_strobe_code) else $error("strobe/rw code wrong");
   property p_odd_word_ram;
      (!CHIP_SELECT_N_OUT && LOW_BYTE_STROBE_N_OUT && ADDRESS_BIT_ZERO_OUT) |-> s_ff.int_ram;
   endproperty
   a_odd_word_ram: assert property (p_odd_word_ram) else $error("odd word not ram");
   property p_addr_one;
      (s_ff.st == ebamc_pkg::ST_ADDR) |=> s_ff.st == ebamc_pkg::ST_DATA && BUS_PHASE_CLOCK_OUT;
   endproperty
   a_addr_one: assert property (p_addr_one) else $error("address phase stretched");
   property p_stretch3;
      (s_ff.st == ebamc_pkg::ST_ADDR && s_ff.lim == 2'h3) |=>
         BUS_PHASE_CLOCK_OUT [*4] ##1 !BUS_PHASE_CLOCK_OUT && CPU_DONE_OUT;
   endproperty
   a_stretch3: assert property (p_stretch3) else $error("stretch length wrong");
   property p_stretch0;
      (s_ff.st == ebamc_pkg::ST_ADDR && s_ff.lim == 2'h0) |=>
         BUS_PHASE_CLOCK_OUT ##1 !BUS_PHASE_CLOCK_OUT;
   endproperty
   a_stretch0: assert property (p_stretch0) else $error("unstretched length wrong");
   property p_hold_high;
      CPU_HOLD_OUT |-> BUS_PHASE_CLOCK_OUT && s_ff.st == ebamc_pkg::ST_DATA ##1 BUS_PHASE_CLOCK_OUT;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("hold outside stretch");
   property p_wdata_held;
      (BUS_PHASE_CLOCK_OUT && $past(BUS_PHASE_CLOCK_OUT) && !READ_WRITE_OUT) |->
         !DATA_OE_N_OUT && $stable(DATA_OUT);
   endproperty
   a_wdata_held: assert property (p_wdata_held) else $error("write data dropped");
   property p_cs_rw_held;
      (BUS_PHASE_CLOCK_OUT && $past(BUS_PHASE_CLOCK_OUT)) |->
         !CHIP_SELECT_N_OUT && $stable(READ_WRITE_OUT);
   endproperty
   a_cs_rw_held: assert property (p_cs_rw_held) else $error("cs or rw moved");
   property p_read_capture;
      ($fell(BUS_PHASE_CLOCK_OUT) && READ_WRITE_OUT) |->
         CPU_DONE_OUT && CPU_RDATA_OUT == lane_swap(ADDRESS_BIT_ZERO_OUT, $past(DATA_IN));
   endproperty
   a_read_capture: assert property (p_read_capture) else $error("read capture wrong");
   property p_tick_free;
      (CPU_HOLD_OUT && s_ff.tick_cnt != TICK_DIV - 8'h01) |=>
         s_ff.tick_cnt == $past(s_ff.tick_cnt) + 8'h01;
   endproperty
   a_tick_free: assert property (p_tick_free) else $error("tick stalled");
   property p_mode_latch;
      $rose(MODE_VALID_OUT) |-> MODE_OUT == $past(s_ff.ms3) &&
         BACKGROUND_DEBUG_MODE_OUT == ($past(s_ff.ms3) == ebamc_pkg::MODE_SPEC_SINGLE ||
         $past(DEBUG_CMD_IN) || $past(BACKGROUND_DEBUG_MODE_OUT));
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("mode latch wrong");
   property p_pipe_hiz;
      !MODE_VALID_OUT |-> PIPE_STATUS_OE_N_OUT;
   endproperty
   a_pipe_hiz: assert property (p_pipe_hiz) else $error("pipe driven early");
   property p_irq_gate;
      IRQ_REQ_OUT |-> $past(s_ff.irq_en) && !$past(s_ff.pin[1]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_cov_wr3;
      (s_ff.st == ebamc_pkg::ST_ADDR && !READ_WRITE_OUT && s_ff.lim == 2'h3);
   endproperty
   c_wr3: cover property (p_cov_wr3);
   property p_cov_odd_rd;
      $fell(BUS_PHASE_CLOCK_OUT) && READ_WRITE_OUT && LOW_BYTE_STROBE_N_OUT && ADDRESS_BIT_ZERO_OUT;
   endproperty
   c_odd_rd: cover property (p_cov_odd_rd);
   property p_cov_err;
      CPU_ERR_OUT;
   endproperty
   c_err: cover property (p_cov_err);
endmodule

// ==== sim/ebamc_ext_mem.sv ====
// partner model: external word memory on the multiplexed bus
`timescale 1ns/1ps
module ebamc_ext_mem (
   input wire logic clk_in,
   input wire logic cs_n_in,
   input wire logic rw_in,
   input wire logic oe_n_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out
);
   logic [15:0] mem_ff [0:255];
   initial
   begin
      foreach (mem_ff[i]) mem_ff[i] = 16'h0000;
      rdata_out = 16'h0000;
   end
   // answers from the address phase on, ahead of the capture fall
   // a released bus toggles each cycle so a stale read never passes
   always @(posedge clk_in)
   begin
      if (!cs_n_in && rw_in)
         rdata_out <= mem_ff[addr_in[8:1]];
      else
         rdata_out <= ~rdata_out;
   end
   always @(posedge clk_in)
   begin
      if (!cs_n_in && !rw_in && !oe_n_in)
         mem_ff[addr_in[8:1]] <= wdata_in;
   end
endmodule

// ==== sim/tb_top.sv ====
// testbench: register reset values, bus encoding, stretch timing, mode latch
`timescale 1ns/1ps
module tb_top;
   logic clk, rst_n, cyc, stb, we, req, cwe, wide, iram, ack, done, err, a0, stb_n, rw, cs_n;
   logic bus_phase_clock, oe_n, dbg, hold, tick, irq_q, nmi_q, mv, background_debug_mode, pipe_oe_n;
   logic [1:0] pins, pu;
   logic [2:0] strap, mo;
   logic [7:0] adr;
   logic [31:0] wdat, rd, wbq;
   logic [15:0] caddr, cwd, din, rdat, xa, dout;
   int mismatches, cmp_count;
   ebamc_top #(.TICK_DIV(8'h02)) u_ebamc_top (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(wbq), .WB_ACK_OUT(ack), .CPU_REQ_IN(req),
      .CPU_ADDR_IN(caddr), .CPU_WE_IN(cwe), .CPU_WIDE_IN(wide), .CPU_INT_RAM_IN(iram),
      .CPU_WDATA_IN(cwd), .CPU_PIPE_IN(2'h0), .DEBUG_CMD_IN(dbg), .CPU_HOLD_OUT(hold),
      .CPU_DONE_OUT(done), .CPU_ERR_OUT(err), .CPU_RDATA_OUT(rdat), .EXT_ADDR_OUT(xa),
      .ADDRESS_BIT_ZERO_OUT(a0), .LOW_BYTE_STROBE_N_OUT(stb_n), .READ_WRITE_OUT(rw),
      .CHIP_SELECT_N_OUT(cs_n), .BUS_PHASE_CLOCK_OUT(bus_phase_clock), .DATA_OUT(dout),
      .DATA_OE_N_OUT(oe_n), .DATA_IN(din), .MODE_PIN_A_IN(strap[0]), .MODE_PIN_B_IN(strap[1]),
      .MODE_PIN_C_IN(strap[2]), .IRQ_N_IN(pins[1]), .NONMASKABLE_INTERRUPT_N_IN(pins[0]),
      .PIPE_STATUS_OUT(), .PIPE_STATUS_OE_N_OUT(pipe_oe_n), .PORT_E_PULLUP_OUT(pu),
      .IRQ_REQ_OUT(irq_q), .NMI_REQ_OUT(nmi_q), .MODE_VALID_OUT(mv), .MODE_OUT(mo),
      .BACKGROUND_DEBUG_MODE_OUT(background_debug_mode), .TIMER_TICK_OUT(tick));
   ebamc_ext_mem u_ebamc_ext_mem (.clk_in(clk), .cs_n_in(cs_n), .rw_in(rw), .oe_n_in(oe_n),
      .addr_in(xa), .wdata_in(dout), .rdata_out(din));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = wbq;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("wb_ack", 1, ack);
   endtask
   // enc is {strobe_n, bit0, rw} as seen in the address phase
   task automatic cpu(input logic w, x, r, input logic [15:0] a, d, input int lat,
      input logic [2:0] enc, input logic e);
      int n, hc;
      logic [2:0] seen;
      logic tk;
      n = 0;
      hc = 0;
      tk = 1'b0;
      seen = 3'h0;
      @(posedge clk);
      req <= 1'b1;
      cwe <= w;
      wide <= x;
      iram <= r;
      caddr <= a;
      cwd <= d;
      do
      begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1 && !e) chk("addr_phase_clk", 0, bus_phase_clock);
         if (n == 1) seen = {stb_n, a0, rw};
         if (x && oe_n === 1'b0)
            chk("bus_data", a[0] ? d : {d[7:0], d[15:8]}, dout);
         // with a divider of two the tick must alternate, even while the cpu is held
         if (hold === 1'b1)
         begin
            hc++;
            chk("tick_free", !tk, tick);
         end
         tk = tick;
      end while (done !== 1'b1 && n < 20);
      req <= 1'b0;
      chk("hold", e ? 0 : lat - 3, hc);
      chk("latency", lat, n);
      chk("refused", e, err);
      if (!e) chk("encoding", enc, seen);
      if (!e && !w && x) chk("rdata", d, rdat);
   endtask
   task automatic t_reset;
      wb(0, 8'h00, 0);
      chk("stretch_en", 1, rd);
      wb(0, 8'h04, 0);
      chk("stretch_cnt", 3, rd);
      wb(0, 8'h08, 0);
      chk("mode", 32'h0b, rd);
      wb(0, 8'h0c, 0);
      chk("port_e", 32'h3c, rd);
      wb(0, 8'h14, 0);
      chk("unmapped", 0, rd);
      chk("mode_pins", 32'h0b, {background_debug_mode, mv, mo});
      chk("pullup", 3, pu);
      chk("pipe_hiz", 1, pipe_oe_n);
      $display("reset test done");
   endtask
   task automatic t_stretch;
      for (int i = 0; i < 4; i++)
      begin
         wb(1, 8'h04, i);
         cpu(1, 1, 0, 16'h0010 + 16'(2 * i), 16'h1234 + 16'(i), 3 + i, 3'b000, 0);
         cpu(0, 1, 0, 16'h0010 + 16'(2 * i), 16'h1234 + 16'(i), 3 + i, 3'b001, 0);
      end
      wb(1, 8'h00, 0);
      cpu(0, 0, 0, 16'h0020, 16'h0000, 3, 3'b101, 0);
      $display("stretch test done");
   endtask
   task automatic t_access;
      cpu(1, 0, 0, 16'h0021, 16'h00a5, 3, 3'b010, 0);
      cpu(1, 1, 1, 16'h0031, 16'hbeef, 3, 3'b110, 0);
      cpu(0, 1, 1, 16'h0031, 16'hbeef, 3, 3'b111, 0);
      cpu(1, 1, 0, 16'h0041, 16'h1111, 1, 3'b000, 1);
      $display("access test done");
   endtask
   task automatic t_port;
      wb(1, 8'h0c, 32'h73);
      @(posedge clk);
      pins <= 2'h0;
      dbg <= 1'b1;
      @(posedge clk);
      dbg <= 1'b0;
      repeat (8) @(posedge clk);
      chk("irq_nmi", 3, {irq_q, nmi_q});
      chk("pipe_drive", 0, pipe_oe_n);
      chk("debug_cmd", 1, background_debug_mode);
      wb(0, 8'h0c, 0);
      chk("port_e_pins", 32'h73, rd);
      pins <= 2'h3;
      $display("port test done");
   endtask
   // second reset mid-run with a normal-mode strap
   task automatic t_normal;
      rst_n <= 1'b0;
      strap <= 3'b111;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      wb(0, 8'h08, 0);
      chk("mode_norm", 32'h0f, rd);
      wb(1, 8'h04, 1);
      wb(1, 8'h04, 2);
      wb(0, 8'h04, 0);
      chk("protect", 1, rd);
      wb(1, 8'h08, 32'h06);
      wb(0, 8'h08, 0);
      chk("mode_refuse", 32'h0f, rd);
      $display("normal mode test done");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #20000;
      mismatches++;
      test_done();
   end
   initial
   begin
      {rst_n, cyc, stb, we, req, cwe, wide, iram, adr, wdat, caddr, cwd, dbg} = '0;
      pins = 2'h3;
      strap = 3'b011; // emulation wide, never the peripheral pattern
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      t_reset();
      t_stretch();
      t_access();
      t_port();
      t_normal();
      test_done();
   end
endmodule
